/* File: hw/ost_cfg.svh */
// Offsets, field positions, reset values and counts of the
// oscillation settling timer. Assumes an 8-bit register port.
`ifndef OST_CFG_SVH
`define OST_CFG_SVH

// Register byte addresses
`define OST_ADDR_RC_MODE 16'hffa0
`define OST_ADDR_MAIN_CTRL 16'hffa2
`define OST_ADDR_STATUS 16'hffa3
`define OST_ADDR_SELECT 16'hffa4
`define OST_ADDR_IRQ_STAT 16'hffa5
`define OST_ADDR_IRQ_MASK 16'hffa6

// Reset values
`define OST_SELECT_RST 3'h5
`define OST_MAIN_HALT_RST 1'h1
`define OST_STATUS_RST 5'h00

// Field positions and widths
`define OST_MAIN_HALT_BIT 7
`define OST_RC_READY_BIT 7
`define OST_SLOW_HALT_BIT 1
`define OST_FAST_HALT_BIT 0
`define OST_SEL_W 3
`define OST_STATUS_W 5
`define OST_IRQ_W 2
`define OST_IRQ_DONE_BIT 0
`define OST_IRQ_BADSEL_BIT 1

// Settling limits in main crystal cycles
`define OST_CNT_W 17
`define OST_LIM_2P11 17'h00800
`define OST_LIM_2P13 17'h02000
`define OST_LIM_2P14 17'h04000
`define OST_LIM_2P15 17'h08000
`define OST_LIM_2P16 17'h10000

// Nominal internal oscillator rates, kHz (for reference only)
`define OST_FAST_RC_KHZ 8000
`define OST_SLOW_RC_KHZ 240

`endif

/* File: hw/ost_pkg.sv */
// Types of the oscillation settling timer.
// Assumes ost_cfg.svh is on the include path.
`include "ost_cfg.svh"

package ost_pkg;

  typedef enum logic [2:0]
  {
    OST_SEL_2P11 = 3'b001,
    OST_SEL_2P13 = 3'b010,
    OST_SEL_2P14 = 3'b011,
    OST_SEL_2P15 = 3'b100,
    OST_SEL_2P16 = 3'b101
  } ost_sel_type;

  typedef enum logic [1:0]
  {
    OST_HOLD_IDLE = 2'b00,
    OST_HOLD_WAIT = 2'b01
  } ost_hold_type;

endpackage

/* File: hw/ost_counter.sv */
// Saturating counter of main crystal cycles.
// Assumes tick is a one-cycle pulse per crystal rising edge.
`include "ost_cfg.svh"

module ost_counter
  import ost_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic clear, // Restart from zero
  input wire logic tick, // One crystal edge seen
  input wire logic [`OST_CNT_W-1:0] limit, // Saturation point
  output logic [`OST_CNT_W-1:0] count_q, // Elapsed cycles
  output logic done_q // Count sits at the limit
);

  logic [`OST_CNT_W-1:0] count_d;
  wire logic below_limit;

  assign below_limit = count_q < limit;

  always_comb
  begin
    count_d = count_q;
    if (clear)
    begin
      count_d = '0;
    end
    else if (tick && below_limit)
    begin
      count_d = count_q + `OST_CNT_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_q <= '0;
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      count_q <= count_d;
      done_q <= (count_d >= limit);
    end
  end

endmodule

/* File: hw/ost_top.sv */
// Main crystal oscillation settling timer with its control registers.
// Assumes a byte register port on clk and a free-running crystal pin.
// Function
// - Status clears on reset, STOP, halt write
// - Status bits set in order, stay set
// - Status readable; bits 7..5 read zero
// - Counting stops at the selected wait
// - Only real crystal edges are counted
// - Hold CPU on crystal after STOP until wait elapses
// - Select codes map to 2^11..2^16 cycles
// - Select resets to 05H, upper bits zero
// - Fast RC runs after reset unless halted
// - Slow RC feeds watchdog and timer only
// - Option byte permits slow RC halt
// - Slow RC runs after reset, clocks watchdog
// - Main halt bit 7 stops crystal
// - Mode bits 1 and 0 halt RC oscillators
//
// The address-and-strobe port is this design's own decision.
`include "ost_cfg.svh"

module ost_top
  import ost_pkg::*;
(
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst, // Synchronous reset, any source
  input wire logic ce, // Clock enable, freezes all state
  input wire logic [15:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata_q, // Read data, cycle after rd
  input wire logic main_crystal, // Main crystal clock pin
  input wire logic stop_exec, // STOP instruction executed
  input wire logic stop_release, // STOP mode released
  input wire logic cpu_on_main, // CPU runs from crystal
  input wire logic opt_slow_stoppable, // Option: slow RC may stop
  input wire logic opt_wdt_enable, // Option: watchdog on
  output logic cpu_hold_q, // Hold CPU while settling
  output logic main_osc_en_q, // Crystal oscillator enable
  output logic fast_rc_en_q, // Fast RC enable
  output logic slow_rc_en_q, // Slow RC enable
  output logic wdt_slow_clk_en_q, // Slow clock to watchdog
  output logic tmr_slow_clk_en_q, // Slow clock to 8-bit timer
  output logic irq_q // Interrupt, level
);

  // Crystal pin synchroniser and edge detector
  logic xtal_s1_q;
  logic xtal_s2_q;
  logic xtal_s3_q;

  // Registers
  logic [`OST_SEL_W-1:0] sel_q;
  logic main_halt_q;
  logic slow_halt_q;
  logic fast_halt_q;
  logic [`OST_STATUS_W-1:0] status_q;
  logic [`OST_STATUS_W-1:0] status_d;
  logic [`OST_IRQ_W-1:0] irq_stat_q;
  logic [`OST_IRQ_W-1:0] irq_stat_d;
  logic [`OST_IRQ_W-1:0] irq_mask_q;
  logic done_prev_q;
  ost_hold_type hold_q;
  ost_hold_type hold_d;

  logic [`OST_CNT_W-1:0] count_q;
  logic done_q;
  logic [7:0] rdata_d;

  function automatic logic [`OST_CNT_W-1:0] sel_limit
    (input logic [`OST_SEL_W-1:0] sel);
    case (sel)
      OST_SEL_2P11: sel_limit = `OST_LIM_2P11;
      OST_SEL_2P13: sel_limit = `OST_LIM_2P13;
      OST_SEL_2P14: sel_limit = `OST_LIM_2P14;
      OST_SEL_2P15: sel_limit = `OST_LIM_2P15;
      default: sel_limit = `OST_LIM_2P16;
    endcase
  endfunction

  function automatic logic sel_legal(input logic [`OST_SEL_W-1:0] sel);
    case (sel)
      OST_SEL_2P11, OST_SEL_2P13, OST_SEL_2P14,
      OST_SEL_2P15, OST_SEL_2P16: sel_legal = 1'b1;
      default: sel_legal = 1'b0;
    endcase
  endfunction

  // Address decode
  wire logic hit_rc = addr == `OST_ADDR_RC_MODE;
  wire logic hit_main = addr == `OST_ADDR_MAIN_CTRL;
  wire logic hit_status = addr == `OST_ADDR_STATUS;
  wire logic hit_sel = addr == `OST_ADDR_SELECT;
  wire logic hit_istat = addr == `OST_ADDR_IRQ_STAT;
  wire logic hit_imask = addr == `OST_ADDR_IRQ_MASK;
  wire logic wr_rc = wr && hit_rc;
  wire logic wr_main = wr && hit_main;
  wire logic wr_sel = wr && hit_sel;
  wire logic wr_istat = wr && hit_istat;
  wire logic wr_imask = wr && hit_imask;

  // Clearing events; reset is handled in the flops themselves
  wire logic halt_write = wr_main && wdata[`OST_MAIN_HALT_BIT];
  wire logic clear_evt = stop_exec || halt_write;

  // Count only synchronised crystal edges while the oscillator is on;
  // the start-up gap before the first edge adds nothing.
  wire logic xtal_tick = xtal_s2_q && !xtal_s3_q && !main_halt_q;

  wire logic [`OST_CNT_W-1:0] limit = sel_limit(sel_q);

  ost_counter u_counter (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(clear_evt),
    .tick(xtal_tick),
    .limit(limit),
    .count_q(count_q),
    .done_q(done_q)
  );

  // Thermometer status from the saturated count
  wire logic [`OST_STATUS_W-1:0] reached =
  {
    count_q >= `OST_LIM_2P11,
    count_q >= `OST_LIM_2P13,
    count_q >= `OST_LIM_2P14,
    count_q >= `OST_LIM_2P15,
    count_q >= `OST_LIM_2P16
  };

  assign status_d = clear_evt ? `OST_STATUS_RST : (status_q | reached);

  // Sticky events: settle done, prohibited select written
  wire logic done_rise = done_q && !done_prev_q;
  wire logic badsel_wr = wr_sel && !sel_legal(wdata[`OST_SEL_W-1:0]);
  wire logic [`OST_IRQ_W-1:0] irq_set = {badsel_wr, done_rise};
  wire logic [`OST_IRQ_W-1:0] irq_clr =
    wr_istat ? wdata[`OST_IRQ_W-1:0] : '0;

  // Set wins over a simultaneous write-one-to-clear
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

  // CPU hold after STOP release, only when running from the crystal
  always_comb
  begin
    case (hold_q)
      OST_HOLD_IDLE:
      begin
        if (stop_release && cpu_on_main && !done_q)
          hold_d = OST_HOLD_WAIT;
        else
          hold_d = OST_HOLD_IDLE;
      end
      OST_HOLD_WAIT:
      begin
        if (done_q)
          hold_d = OST_HOLD_IDLE;
        else
          hold_d = OST_HOLD_WAIT;
      end
      default: hold_d = OST_HOLD_IDLE;
    endcase
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (hit_rc)
    begin
      rdata_d[`OST_RC_READY_BIT] = !fast_halt_q;
      rdata_d[`OST_SLOW_HALT_BIT] = slow_halt_q;
      rdata_d[`OST_FAST_HALT_BIT] = fast_halt_q;
    end
    else if (hit_main)
      rdata_d[`OST_MAIN_HALT_BIT] = main_halt_q;
    else if (hit_status)
      rdata_d[`OST_STATUS_W-1:0] = status_q;
    else if (hit_sel)
      rdata_d[`OST_SEL_W-1:0] = sel_q;
    else if (hit_istat)
      rdata_d[`OST_IRQ_W-1:0] = irq_stat_q;
    else if (hit_imask)
      rdata_d[`OST_IRQ_W-1:0] = irq_mask_q;
  end

  // Only the second and third stages feed the edge detector
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      xtal_s3_q <= 1'b0;
    end
    else if (ce)
    begin
      xtal_s1_q <= main_crystal;
      xtal_s2_q <= xtal_s1_q;
      xtal_s3_q <= xtal_s2_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_q <= `OST_SELECT_RST;
      main_halt_q <= `OST_MAIN_HALT_RST;
      slow_halt_q <= 1'b0;
      fast_halt_q <= 1'b0;
      irq_mask_q <= '0;
    end
    else if (ce)
    begin
      if (wr_sel)
        sel_q <= wdata[`OST_SEL_W-1:0];
      if (wr_main)
        main_halt_q <= wdata[`OST_MAIN_HALT_BIT];
      if (wr_rc)
      begin
        slow_halt_q <= wdata[`OST_SLOW_HALT_BIT];
        fast_halt_q <= wdata[`OST_FAST_HALT_BIT];
      end
      if (wr_imask)
        irq_mask_q <= wdata[`OST_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_q <= `OST_STATUS_RST;
      irq_stat_q <= '0;
      done_prev_q <= 1'b0;
      hold_q <= OST_HOLD_IDLE;
      cpu_hold_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else if (ce)
    begin
      status_q <= status_d;
      irq_stat_q <= irq_stat_d;
      done_prev_q <= done_q;
      hold_q <= hold_d;
      cpu_hold_q <= hold_d == OST_HOLD_WAIT;
      rdata_q <= rd ? rdata_d : 8'h00;
    end
  end

  // Oscillator enables; the slow clock has no path to the CPU at all
  wire logic slow_run = !(slow_halt_q && opt_slow_stoppable);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      main_osc_en_q <= 1'b0;
      fast_rc_en_q <= 1'b1;
      slow_rc_en_q <= 1'b1;
      wdt_slow_clk_en_q <= 1'b0;
      tmr_slow_clk_en_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      main_osc_en_q <= !main_halt_q;
      fast_rc_en_q <= !fast_halt_q;
      slow_rc_en_q <= slow_run;
      wdt_slow_clk_en_q <= slow_run && opt_wdt_enable;
      tmr_slow_clk_en_q <= slow_run;
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  // Checks
  status_clr_a: assert property (@(posedge clk) disable iff (rst)
    ce && clear_evt |=> status_q == `OST_STATUS_RST)
    else $error("status not cleared");

  status_therm_a: assert property (@(posedge clk) disable iff (rst)
    status_q inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f})
    else $error("status not thermometer coded");

  status_keep_a: assert property (@(posedge clk) disable iff (rst)
    ce && !clear_evt |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("status bit dropped");

  status_read_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd && hit_status |=> rdata_q == {3'b000, $past(status_q)})
    else $error("status read wrong");

  limit_cap_a: assert property (@(posedge clk) disable iff (rst)
    count_q <= limit || $past(wr_sel))
    else $error("count passed the selected limit");

  edge_only_a: assert property (@(posedge clk) disable iff (rst)
    ce && !xtal_tick && !clear_evt |=> count_q == $past(count_q))
    else $error("count moved without a crystal edge");

  hold_end_a: assert property (@(posedge clk) disable iff (rst)
    ce && cpu_hold_q && done_q |=> !cpu_hold_q)
    else $error("hold kept after wait elapsed");

  hold_start_a: assert property (@(posedge clk) disable iff (rst)
    ce && stop_release && cpu_on_main && !done_q && !clear_evt
    |=> cpu_hold_q)
    else $error("hold not raised on release");

  sel_decode_a: assert property (@(posedge clk) disable iff (rst)
    sel_q == 3'b001 |-> limit == 17'h00800)
    else $error("select decode wrong");

  sel_reset_a: assert property (@(posedge clk)
    $past(rst) |-> sel_q == 3'h5)
    else $error("select reset value wrong");

  slow_keep_a: assert property (@(posedge clk) disable iff (rst)
    ce && !opt_slow_stoppable |=> slow_rc_en_q)
    else $error("slow RC stopped while not permitted");

  // The enable flop lags the halt bit by one more enabled cycle
  main_halt_a: assert property (@(posedge clk) disable iff (rst)
    ce && halt_write ##1 ce |=> !main_osc_en_q)
    else $error("crystal not stopped by halt bit");

  settle_done_c: cover property (@(posedge clk) disable iff (rst)
    done_rise);

  hold_release_c: cover property (@(posedge clk) disable iff (rst)
    cpu_hold_q ##1 !cpu_hold_q);

  irq_fire_c: cover property (@(posedge clk) disable iff (rst)
    !irq_q ##1 irq_q);

endmodule

/* File: tb/ost_crystal.sv */
// Resonator model on the main crystal pin.
// Assumes en follows the oscillator enable of the settling timer.
module ost_crystal #(
  parameter int START_NS = 2001, // Start-up; odd ns keeps swings off clk
  parameter int HALF_NS = 10 // 50 MHz, well below sync limit
)
(
  input wire logic en, // Oscillator enabled
  output logic xtal // Crystal clock, low while stopped
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    xtal = 1'b0;
    forever
    begin
      wait (en === 1'b1);
      // No edges at all during start-up, so none can be counted
      #START_NS;
      while (en === 1'b1)
      begin
        #HALF_NS xtal = 1'b1;
        #HALF_NS xtal = 1'b0;
      end
    end
  end
endmodule

/* File: tb/ost_top_tb.sv */
// Self-checking bench of the oscillation settling timer.
// Assumes the crystal model starts 2 us after its enable rises.
`include "ost_cfg.svh"

module ost_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, xtal;
  logic stop_exec = 0, stop_release = 0, cpu_on_main = 0;
  logic opt_slow = 0, opt_wdt = 1, ce = 1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata_q;
  logic hold, main_en, fast_en, slow_en, wdt_en, tmr_en, irq;
  int miscompares = 0, comparisons = 0, cycles = 0;

  ost_top u_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .main_crystal(xtal), .stop_exec(stop_exec),
    .stop_release(stop_release), .cpu_on_main(cpu_on_main),
    .opt_slow_stoppable(opt_slow), .opt_wdt_enable(opt_wdt),
    .cpu_hold_q(hold), .main_osc_en_q(main_en), .fast_rc_en_q(fast_en),
    .slow_rc_en_q(slow_en), .wdt_slow_clk_en_q(wdt_en),
    .tmr_slow_clk_en_q(tmr_en), .irq_q(irq));
  ost_crystal u_xtal (.en(main_en), .xtal(xtal));

  initial
  forever
    #2.5 clk = ~clk;

  task automatic summarize;
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Ceiling leaves headroom over the longest settling wait the bench runs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_q;
  endtask

  task automatic rchk(input string name, input logic [15:0] a,
    input logic [7:0] exp);
    logic [7:0] d;
    rreg(a, d);
    chk(name, d, exp);
  endtask

  // Let registered outputs catch up with the last request
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wait_status(input logic [7:0] exp, output int n);
    logic [7:0] d;
    int t0;
    t0 = cycles;
    d = 8'h00;
    while (d !== exp && cycles - t0 < 40000)
      rreg(`OST_ADDR_STATUS, d);
    n = cycles - t0;
  endtask

  task automatic t_reset;
    rchk("rc", `OST_ADDR_RC_MODE, 8'h80);
    rchk("main", `OST_ADDR_MAIN_CTRL, 8'h80);
    rchk("status", `OST_ADDR_STATUS, 8'h00);
    rchk("select", `OST_ADDR_SELECT, 8'h05);
    rchk("irqst", `OST_ADDR_IRQ_STAT, 8'h00);
    rchk("mask", `OST_ADDR_IRQ_MASK, 8'h00);
    rchk("unmapped", 16'hffa7, 8'h00);
    chk("main_en", main_en, 1'b0);
    chk("fast_en", fast_en, 1'b1);
    chk("slow_en", slow_en, 1'b1);
    chk("tmr_en", tmr_en, 1'b1);
    chk("wdt_en", wdt_en, 1'b1);
    chk("irq", irq, 1'b0);
  endtask

  task automatic t_select;
    logic bad;
    for (int c = 0; c < 8; c++)
    begin
      bad = (c == 0 || c > 5);
      wreg(`OST_ADDR_SELECT, {5'h1f, 3'(c)});
      rchk("select", `OST_ADDR_SELECT, {5'h00, 3'(c)});
      rchk("badsel", `OST_ADDR_IRQ_STAT, {6'h00, bad, 1'b0});
      wreg(`OST_ADDR_IRQ_STAT, 8'h02);
    end
    wreg(`OST_ADDR_STATUS, 8'hff);
    rchk("status_ro", `OST_ADDR_STATUS, 8'h00);
    // Select is fixed before the crystal starts its wait
    wreg(`OST_ADDR_SELECT, 8'h01);
  endtask

  task automatic t_settle;
    int n;
    wreg(`OST_ADDR_IRQ_MASK, 8'h01);
    wreg(`OST_ADDR_MAIN_CTRL, 8'h00);
    wait_status(8'h10, n);
    chk("t2p11", (n >= 8560 && n <= 8640), 1'b1);
    repeat (3000) @(posedge clk);
    rchk("status_sat", `OST_ADDR_STATUS, 8'h10);
    chk("irq_on", irq, 1'b1);
    wreg(`OST_ADDR_IRQ_MASK, 8'h00);
    settle();
    chk("irq_masked", irq, 1'b0);
    wreg(`OST_ADDR_IRQ_MASK, 8'h01);
    settle();
    chk("irq_unmask", irq, 1'b1);
    wreg(`OST_ADDR_IRQ_STAT, 8'h01);
    settle();
    chk("irq_clr", irq, 1'b0);
    rchk("irqst_clr", `OST_ADDR_IRQ_STAT, 8'h00);
  endtask

  task automatic t_stop;
    int n, t0;
    wreg(`OST_ADDR_SELECT, 8'h02);
    @(posedge clk);
    stop_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    stop_release <= 1'b1;
    cpu_on_main <= 1'b1;
    t0 = cycles;
    @(posedge clk);
    stop_release <= 1'b0;
    settle();
    chk("hold_on", hold, 1'b1);
    rchk("status_stop", `OST_ADDR_STATUS, 8'h00);
    wait_status(8'h10, n);
    chk("hold_mid", hold, 1'b1);
    while (hold === 1'b1 && cycles - t0 < 40000)
      @(posedge clk);
    n = cycles - t0;
    chk("t2p13", (n >= 32700 && n <= 32900), 1'b1);
    rchk("status_13", `OST_ADDR_STATUS, 8'h18);
    wreg(`OST_ADDR_IRQ_STAT, 8'h01);
  endtask

  task automatic t_halt;
    cpu_on_main <= 1'b0;
    @(posedge clk);
    stop_release <= 1'b1;
    @(posedge clk);
    stop_release <= 1'b0;
    settle();
    chk("hold_off", hold, 1'b0);
    wreg(`OST_ADDR_MAIN_CTRL, 8'h80);
    rchk("status_halt", `OST_ADDR_STATUS, 8'h00);
    chk("main_off", main_en, 1'b0);
    repeat (3000) @(posedge clk);
    rchk("status_idle", `OST_ADDR_STATUS, 8'h00);
  endtask

  task automatic t_rc;
    wreg(`OST_ADDR_RC_MODE, 8'h03);
    settle();
    chk("fast_off", fast_en, 1'b0);
    chk("slow_kept", slow_en, 1'b1);
    rchk("rc_rd", `OST_ADDR_RC_MODE, 8'h03);
    @(posedge clk);
    opt_slow <= 1'b1;
    settle();
    chk("slow_off", slow_en, 1'b0);
    chk("tmr_off", tmr_en, 1'b0);
    chk("wdt_off", wdt_en, 1'b0);
    wreg(`OST_ADDR_RC_MODE, 8'h00);
    settle();
    chk("slow_on", slow_en, 1'b1);
    chk("wdt_on", wdt_en, 1'b1);
    @(posedge clk);
    opt_wdt <= 1'b0;
    settle();
    chk("wdt_opt", wdt_en, 1'b0);
    chk("tmr_on", tmr_en, 1'b1);
  endtask

  // A write while ce is low must be lost; read data falls back to zero
  task automatic t_ce;
    @(posedge clk);
    ce <= 1'b0;
    wreg(`OST_ADDR_SELECT, 8'h03);
    ce <= 1'b1;
    rchk("select_frozen", `OST_ADDR_SELECT, 8'h02);
    @(posedge clk);
    #1 chk("rdata_idle", rdata_q, 8'h00);
  endtask

  task automatic t_rst;
    int n;
    wreg(`OST_ADDR_SELECT, 8'h01);
    wreg(`OST_ADDR_MAIN_CTRL, 8'h00);
    wait_status(8'h10, n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk("status_rst", `OST_ADDR_STATUS, 8'h00);
    rchk("select_rst", `OST_ADDR_SELECT, 8'h05);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_select();
    t_settle();
    t_stop();
    t_halt();
    t_rc();
    t_ce();
    t_rst();
    summarize();
  end
endmodule
